//--- dv/host_serial_port_cmd_fifo_bench.sv
/* Bench: host model drives the port, a queue holds expected bytes.
   Assumes the host model's frame() and a 50 MHz clk_sys. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check((g), (e))
module host_serial_port_cmd_fifo_bench;
   logic        clk_sys = 1'b0, resetn = 1'b0;
   logic        cmdReady = 1'b0, cmdExecDone = 1'b0, run = 1'b0;
   wire         spiSclk, spiCsN, cmdValid;
   wire  [3:0]  laneIn, laneOut, laneOe;
   wire  [7:0]  cmdData;
   wire  [1:0]  laneWidth;
   wire  [11:0] cmdWritePtr, cmdReadPtr;
   logic [11:0] expQ[$];
   logic [1:0]  codes[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
   logic [7:0]  d;
   logic [11:0] a;
   int          err_count = 0, n_tests = 0;
   always #10 clk_sys = ~clk_sys;
   hsp_serial_port u_hsp_serial_port (.clk_sys(clk_sys), .resetn(resetn),
      .spiSclk(spiSclk), .spiCsN(spiCsN), .laneIn(laneIn),
      .laneOut(laneOut), .laneOe(laneOe), .cmdValid(cmdValid),
      .cmdData(cmdData), .cmdReady(cmdReady), .cmdExecDone(cmdExecDone),
      .laneWidth(laneWidth), .cmdWritePtr(cmdWritePtr),
      .cmdReadPtr(cmdReadPtr));
   hsp_host_model u_hsp_host_model (.clk_sys(clk_sys), .spiSclk(spiSclk),
      .spiCsN(spiCsN), .laneIn(laneIn), .laneOut(laneOut), .laneOe(laneOe));
   task automatic check(input logic [11:0] g, input logic [11:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      u_hsp_host_model.frame(1'b1, a, d);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      expQ.push_back(e);
      u_hsp_host_model.frame(1'b0, a, 8'h00);
   endtask
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Executor stalls at random, so bytes are held and taken unevenly
   always @(posedge clk_sys) cmdReady <= run && ($urandom % 2);
   // Oldest expectation meets each fetched byte or read-back byte
   always @(posedge clk_sys)
      if ((cmdValid && cmdReady) || u_hsp_host_model.rdStrobe)
         `CHK((cmdValid && cmdReady) ? cmdData : u_hsp_host_model.rdByte,
              expQ.pop_front());
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      complete_run();
   end
   initial begin
      void'($urandom(7466));
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      `CHK(laneWidth, 2'h0);
      rd(15'h1000, 8'h00);
      rd(15'h1002, 8'h00);
      // Each width code, then memory traffic in the new lane count
      foreach (codes[i]) begin
         d = 8'($urandom);
         a = 12'($urandom);
         wr(15'h1000, {6'h00, codes[i]});
         u_hsp_host_model.width <= codes[i];
         `CHK(laneWidth, codes[i]);
         wr({3'h0, a}, d);
         rd({3'h0, a}, d);
         rd(15'h1000, {6'h00, codes[i]});
      end
      // Fill memory first, then publish a pointer written past the top
      for (int i = 0; i < 5; i++) begin
         d = 8'($urandom);
         wr(15'(i), d);
         expQ.push_back({4'h0, d});
      end
      wr(15'h1004, 8'h05);
      wr(15'h1005, 8'h10);
      `CHK(cmdWritePtr, 12'h005);
      run <= 1'b1;
      for (int k = 0; k < 300 && expQ.size() != 0; k++) @(posedge clk_sys);
      run <= 1'b0;
      @(posedge clk_sys);
      `CHK(cmdValid, 1'b0);
      rd(15'h1008, 8'h00);
      cmdExecDone <= 1'b1;
      @(posedge clk_sys);
      cmdExecDone <= 1'b0;
      rd(15'h1008, 8'h05);
      rd(15'h1009, 8'h00);
      `CHK(cmdReadPtr, 12'h005);
      complete_run();
   end
endmodule // host_serial_port_cmd_fifo_bench
`default_nettype wire

//--- dv/hsp_host_model.sv
/* Host model: serial master, mode 0, one, two or four lanes.
   Assumes the bench calls frame() at a clk_sys rising edge. */
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model (
   // Clock
   input  wire logic       clk_sys,
   // Serial pins
   output var  logic       spiSclk,
   output var  logic       spiCsN,
   output wire logic [3:0] laneIn,
   input  wire logic [3:0] laneOut,
   input  wire logic [3:0] laneOe
);
   logic [1:0] width = 2'h0;
   logic [3:0] drv = 4'h0, hOe = 4'h0, noise = 4'h0;
   logic [7:0] rx = 8'h00, rdByte = 8'h00;
   logic       rdStrobe = 1'b0;
   initial begin
      spiSclk = 1'b0;
      spiCsN = 1'b1;
   end
   // Released lanes toggle so a stale level never reads as valid
   always @(posedge clk_sys) noise <= 4'($urandom);
   assign laneIn = (laneOe & laneOut) | (~laneOe & hOe & drv)
                 | (~laneOe & ~hOe & noise);
   // One byte each way, MSB first; reserved code falls back to one lane
   task automatic xbyte(input logic [7:0] tx, input logic rel);
      int n;
      n = (width == 2'h1) ? 2 : (width == 2'h2) ? 4 : 1;
      for (int i = 0; i < 8 / n; i++) begin
         hOe <= (rel && n > 1) ? 4'h0 : (n == 1) ? 4'h1 : (n == 2) ? 4'h3
              : 4'hF;
         drv <= (n == 1) ? {3'h0, tx[7]} : (n == 2) ? {2'h0, tx[7:6]}
              : tx[7:4];
         tx = tx << n;
         repeat (4) @(posedge clk_sys);
         spiSclk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rx = (n == 1) ? {rx[6:0], laneOut[1]} : (n == 2) ?
              {rx[5:0], laneOut[1:0]} : {rx[3:0], laneOut};
         spiSclk <= 1'b0;
      end
   endtask
   // Whole frame: width changes go over the port itself
   task automatic frame(input logic wr, input logic [14:0] a,
                        input logic [7:0] d);
      spiCsN <= 1'b0;
      repeat (4) @(posedge clk_sys);
      xbyte({wr, a[14:8]}, 1'b0);
      xbyte(a[7:0], 1'b0);
      if (!wr) xbyte(8'h00, 1'b1);
      xbyte(d, !wr);
      repeat (4) @(posedge clk_sys);
      spiCsN <= 1'b1;
      hOe <= 4'h0;
      rdByte <= rx;
      rdStrobe <= !wr;
      @(posedge clk_sys);
      rdStrobe <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
endmodule // hsp_host_model
`default_nettype wire

//--- dv/hsp_port_chk.sv
/* Checker for lane enables, width changes and the fetch handshake.
   Assumes it is bound to hsp_serial_port. */
`timescale 1ns/1ps
`default_nettype none
module hsp_port_chk #(
   parameter AW = 12
) (
   input wire logic          clk_sys,
   input wire logic          resetn,
   input wire logic          spiSclk,
   input wire logic          spiCsN,
   input wire logic [3:0]    laneIn,
   input wire logic [3:0]    laneOut,
   input wire logic [3:0]    laneOe,
   input wire logic          cmdValid,
   input wire logic [7:0]    cmdData,
   input wire logic          cmdReady,
   input wire logic          cmdExecDone,
   input wire logic [1:0]    laneWidth,
   input wire logic [AW-1:0] cmdWritePtr,
   input wire logic [AW-1:0] cmdReadPtr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_take; cmdValid && cmdReady; endsequence
   sequence s_csIdle; spiCsN [*6]; endsequence
   sequence s_sckHigh; (!spiCsN && spiSclk) [*3]; endsequence
   property p_rst_single; !$past(resetn) |-> laneWidth == 2'h0; endproperty
   a_rst_single: assert property (p_rst_single) else $error("width");
   property p_oe_idle; s_csIdle |-> laneOe == 4'h0; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("idle oe");
   property p_oe_legal; laneOe inside {4'h0, 4'h2, 4'h3, 4'hF};
   endproperty
   a_oe_legal: assert property (p_oe_legal) else $error("oe code");
   property p_single_oe; !spiCsN && !$past(spiCsN, 4) &&
      laneWidth inside {2'h0, 2'h3} |-> laneOe inside {4'h0, 4'h2};
   endproperty
   a_single_oe: assert property (p_single_oe) else $error("1 lane");
   property p_width_idle; $changed(laneWidth) |-> $past(spiCsN);
   endproperty
   a_width_idle: assert property (p_width_idle) else $error("w");
   property p_out_stable; s_sckHigh |-> $stable(laneOut); endproperty
   a_out_stable: assert property (p_out_stable) else $error("out");
   property p_bubble; s_take |=> !cmdValid; endproperty
   a_bubble: assert property (p_bubble) else $error("bubble");
   property p_hold; cmdValid && !cmdReady |=> cmdValid && $stable(cmdData);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_rptr; $changed(cmdReadPtr) |-> $past(cmdExecDone);
   endproperty
   a_rptr: assert property (p_rptr) else $error("read ptr");
   property p_empty; cmdReadPtr == cmdWritePtr |-> !cmdValid; endproperty
   a_empty: assert property (p_empty) else $error("empty");
endmodule // hsp_port_chk
bind hsp_serial_port hsp_port_chk #(.AW(AW)) u_chk (.clk_sys(clk_sys),
   .resetn(resetn), .spiSclk(spiSclk), .spiCsN(spiCsN), .laneIn(laneIn),
   .laneOut(laneOut), .laneOe(laneOe), .cmdValid(cmdValid),
   .cmdData(cmdData), .cmdReady(cmdReady), .cmdExecDone(cmdExecDone),
   .laneWidth(laneWidth), .cmdWritePtr(cmdWritePtr),
   .cmdReadPtr(cmdReadPtr));
`default_nettype wire

//--- verilog/hsp_cmd_ram.v
/*
 Command FIFO storage: one write port and two synchronous read ports.
 Assumes a single clock; read data appears one edge after the address.
*/
`timescale 1ns/1ps
`default_nettype none

module hsp_cmd_ram #(
   parameter AW = 12
) (
   // Clock
   input  wire          clk_sys,
   // Serial side write and read
   input  wire          wrEn,
   input  wire [AW-1:0] addrA,
   input  wire [7:0]    wrData,
   output reg  [7:0]    qA,
   // Command fetch side read
   input  wire [AW-1:0] addrB,
   output reg  [7:0]    qB
);

   reg [7:0] mem [0:(1<<AW)-1];

   // Storage has no reset; contents are defined by what the host writes
   always @(posedge clk_sys) begin
      if (wrEn) begin
         mem[addrA] <= wrData;
      end
      qA <= mem[addrA];
      qB <= mem[addrB];
   end

endmodule // hsp_cmd_ram

`default_nettype wire

//--- verilog/hsp_map.vh
/*
 Address map, field codes and reset values for the host serial port
 and its command FIFO.
 Assumes it is included by bare name from the design files.
*/
`ifndef HSP_MAP_VH
`define HSP_MAP_VH

// Command memory: byte addresses below the register base
`define HSP_RAM_AW        12
`define HSP_REG_BASE      15'h1000

// Registers, one byte each, on the serial address space
`define HSP_ADDR_LANE     15'h1000
`define HSP_ADDR_WPTR_LO  15'h1004
`define HSP_ADDR_WPTR_HI  15'h1005
`define HSP_ADDR_RPTR_LO  15'h1008
`define HSP_ADDR_RPTR_HI  15'h1009

// Lane width codes
`define HSP_LANE_SINGLE   2'h0
`define HSP_LANE_DUAL     2'h1
`define HSP_LANE_QUAD     2'h2
`define HSP_LANE_RSVD     2'h3
`define HSP_LANE_RST      2'h0

// Frame phases, counted in whole bytes since select
`define HSP_PH_ADDR_HI    2'h0
`define HSP_PH_ADDR_LO    2'h1
`define HSP_PH_FIRST      2'h2
`define HSP_PH_READ       2'h3

`endif

//--- verilog/hsp_serial_port.v
/*
 Host serial port slave with lane-width control and the command FIFO
 pointers and fetch path.
 Assumes the serial clock, select and lanes come from the host domain
 and are far slower than clk_sys; the executor sits on clk_sys.
 Frame: byte0 = {write, addr[14:8]}, byte1 = addr[7:0], then data
 (writes) or one dummy byte followed by data (reads), address
 incrementing per byte. Mode 0: sample on rise, change on fall.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hsp_map.vh"

module hsp_serial_port #(
   parameter AW = `HSP_RAM_AW
) (
   // Clock and reset
   input  wire          clk_sys,
   input  wire          resetn,
   // Serial pins from the host
   input  wire          spiSclk,
   input  wire          spiCsN,
   input  wire [3:0]    laneIn,
   output reg  [3:0]    laneOut,
   output reg  [3:0]    laneOe,
   // Command executor
   output wire          cmdValid,
   output wire [7:0]    cmdData,
   input  wire          cmdReady,
   input  wire          cmdExecDone,
   // Status
   output wire [1:0]    laneWidth,
   output wire [AW-1:0] cmdWritePtr,
   output wire [AW-1:0] cmdReadPtr
);

   reg  [5:0]    syncA_r;
   reg  [5:0]    syncB_r;
   reg           sckPrev_r;
   reg  [1:0]    width_r;
   reg  [1:0]    pendWidth_r;
   reg           pendValid_r;
   reg  [7:0]    rxSh_r;
   reg  [3:0]    bitCnt_r;
   reg  [1:0]    phase_r;
   reg           isWrite_r;
   reg  [14:0]   addr_r;
   reg  [7:0]    txSh_r;
   reg           drive_r;
   reg  [7:0]    wptrLo_r;
   reg  [AW-1:0] wrPtr_r;
   reg  [AW-1:0] rdPtr_r;
   reg  [AW-1:0] fetchPtr_r;
   reg           qBOk_r;
   reg  [2:0]    step;
   reg  [7:0]    rxNext;
   reg  [7:0]    rdData;
   wire [7:0]    ramQA;
   wire [15:0]   wp16;
   wire [15:0]   rp16;
   wire          csN;
   wire          sckS;
   wire [3:0]    lanesS;
   wire          sckRise;
   wire          sckFall;
   wire          byteDone;
   wire          isReg;
   wire          ramWe;
   wire          cmdTake;

   // Pins cross into clk_sys through two flops before any use
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         syncA_r   <= 6'h20;
         syncB_r   <= 6'h20;
         sckPrev_r <= 1'b0;
      end else begin
         syncA_r   <= {spiCsN, spiSclk, laneIn};
         syncB_r   <= syncA_r;
         sckPrev_r <= syncB_r[4];
      end
   end

   assign csN     = syncB_r[5];
   assign sckS    = syncB_r[4];
   assign lanesS  = syncB_r[3:0];
   assign sckRise = sckS & ~sckPrev_r & ~csN;
   assign sckFall = ~sckS & sckPrev_r & ~csN;

   // Bits per serial edge; the reserved code behaves as single lane
   always @* begin
      case (width_r)
         `HSP_LANE_DUAL: step = 3'h2;
         `HSP_LANE_QUAD: step = 3'h4;
         default:        step = 3'h1;
      endcase
   end

   // Byte assembly, most significant bits first
   always @* begin
      case (width_r)
         `HSP_LANE_DUAL: rxNext = {rxSh_r[5:0], lanesS[1:0]};
         `HSP_LANE_QUAD: rxNext = {rxSh_r[3:0], lanesS};
         default:        rxNext = {rxSh_r[6:0], lanesS[0]};
      endcase
   end

   assign byteDone = sckRise && ((bitCnt_r + {1'b0, step}) == 4'h8);
   assign isReg    = (addr_r >= `HSP_REG_BASE);
   assign ramWe    = byteDone && (phase_r == `HSP_PH_FIRST) && isWrite_r
                     && !isReg;
   assign wp16     = {{(16-AW){1'b0}}, wrPtr_r};
   assign rp16     = {{(16-AW){1'b0}}, rdPtr_r};

   // Read data for the current address; memory data is one edge late,
   // which is harmless since serial edges are many clocks apart
   always @* begin
      if (!isReg) begin
         rdData = ramQA;
      end else begin
         case (addr_r)
            `HSP_ADDR_LANE:    rdData = {6'h00, width_r};
            `HSP_ADDR_WPTR_LO: rdData = wp16[7:0];
            `HSP_ADDR_WPTR_HI: rdData = wp16[15:8];
            `HSP_ADDR_RPTR_LO: rdData = rp16[7:0];
            `HSP_ADDR_RPTR_HI: rdData = rp16[15:8];
            default:           rdData = 8'h00;
         endcase
      end
   end

   // Frame engine: address capture, data phase, shifting out
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rxSh_r    <= 8'h00;
         bitCnt_r  <= 4'h0;
         phase_r   <= `HSP_PH_ADDR_HI;
         isWrite_r <= 1'b0;
         addr_r    <= 15'h0000;
         txSh_r    <= 8'h00;
         drive_r   <= 1'b0;
      end else if (csN) begin
         bitCnt_r  <= 4'h0;
         phase_r   <= `HSP_PH_ADDR_HI;
         drive_r   <= 1'b0;
      end else begin
         if (sckRise) begin
            rxSh_r <= rxNext;
            if (byteDone) begin
               bitCnt_r <= 4'h0;
            end else begin
               bitCnt_r <= bitCnt_r + {1'b0, step};
            end
         end
         if (byteDone) begin
            case (phase_r)
               `HSP_PH_ADDR_HI: begin
                  isWrite_r    <= rxNext[7];
                  addr_r[14:8] <= rxNext[6:0];
                  phase_r      <= `HSP_PH_ADDR_LO;
               end
               `HSP_PH_ADDR_LO: begin
                  addr_r[7:0] <= rxNext;
                  phase_r     <= `HSP_PH_FIRST;
               end
               `HSP_PH_FIRST: begin
                  // Writes stay here; a read's dummy byte ends here
                  if (!isWrite_r) begin
                     txSh_r  <= rdData;
                     drive_r <= 1'b1;
                     phase_r <= `HSP_PH_READ;
                  end
                  addr_r <= addr_r + 15'h0001;
               end
               default: begin
                  txSh_r <= rdData;
                  addr_r <= addr_r + 15'h0001;
               end
            endcase
         end else if (sckFall && drive_r) begin
            // The lane stage takes the old top bits on this same fall,
            // so shifting here lines up the next bits for the next fall
            txSh_r <= txSh_r << step;
         end
      end
   end

   // Lane drive: output bits change on falling edges only
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         laneOut <= 4'h0;
         laneOe  <= 4'h0;
      end else begin
         if (sckFall) begin
            case (width_r)
               `HSP_LANE_DUAL: laneOut <= {2'h0, txSh_r[7:6]};
               `HSP_LANE_QUAD: laneOut <= txSh_r[7:4];
               default:        laneOut <= {2'h0, txSh_r[7], 1'b0};
            endcase
         end
         if (csN) begin
            laneOe <= 4'h0;
         end else if (width_r == `HSP_LANE_DUAL) begin
            laneOe <= drive_r && sckFall ? 4'h3 :
                      (drive_r ? laneOe : 4'h0);
         end else if (width_r == `HSP_LANE_QUAD) begin
            laneOe <= drive_r && sckFall ? 4'hF :
                      (drive_r ? laneOe : 4'h0);
         end else begin
            laneOe <= 4'h2;
         end
      end
   end

   // Registers written over the port; width waits for end of frame
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         width_r     <= `HSP_LANE_RST;
         pendWidth_r <= `HSP_LANE_RST;
         pendValid_r <= 1'b0;
         wptrLo_r    <= 8'h00;
         wrPtr_r     <= {AW{1'b0}};
      end else begin
         if (csN && pendValid_r) begin
            width_r     <= pendWidth_r;
            pendValid_r <= 1'b0;
         end
         if (byteDone && phase_r == `HSP_PH_FIRST && isWrite_r) begin
            case (addr_r)
               `HSP_ADDR_LANE: begin
                  pendWidth_r <= rxNext[1:0];
                  pendValid_r <= 1'b1;
               end
               `HSP_ADDR_WPTR_LO: wptrLo_r <= rxNext;
               // Pointer moves only on the high byte, so the executor
               // never sees half an update
               `HSP_ADDR_WPTR_HI:
                  wrPtr_r <= wp16New(rxNext, wptrLo_r);
               default: ;
            endcase
         end
      end
   end

   function [AW-1:0] wp16New;
      input [7:0] hi;
      input [7:0] lo;
      reg   [15:0] full;
      begin
         full    = {hi, lo};
         wp16New = full[AW-1:0];
      end
   endfunction

   // Fetch runs ahead; the read pointer moves only once executed
   assign cmdTake  = cmdValid & cmdReady;
   assign cmdValid = qBOk_r && (fetchPtr_r != wrPtr_r);
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fetchPtr_r <= {AW{1'b0}};
         rdPtr_r    <= {AW{1'b0}};
         qBOk_r     <= 1'b0;
      end else begin
         if (cmdTake) begin
            fetchPtr_r <= fetchPtr_r + {{(AW-1){1'b0}}, 1'b1};
            qBOk_r     <= 1'b0;
         end else begin
            qBOk_r     <= 1'b1;
         end
         if (cmdExecDone) begin
            rdPtr_r <= fetchPtr_r;
         end
      end
   end

   hsp_cmd_ram #(
      .AW     (AW)
   ) u_ram (
      .clk_sys (clk_sys),
      .wrEn    (ramWe),
      .addrA   (addr_r[AW-1:0]),
      .wrData  (rxNext),
      .qA      (ramQA),
      .addrB   (fetchPtr_r),
      .qB      (cmdData)
   );

   assign laneWidth   = width_r;
   assign cmdWritePtr = wrPtr_r;
   assign cmdReadPtr  = rdPtr_r;

endmodule // hsp_serial_port

`default_nettype wire
